// ==== inc/kpm_cfg.svh ====
// Constants for the keypad number-entry and menu interpreter.
// Assumes a 20 MHz pclk and an APB bus with 32-bit data.
`ifndef KPM_CFG_SVH
`define KPM_CFG_SVH

// ==================================================
// Clock and timing
`define KPM_CLK_HZ          20000000
`define KPM_DEBOUNCE_MS     10
`define KPM_SETUP_HOLD_MS   1000
`define KPM_BLINK_HALF_MS   250
// Divide first: the product of milliseconds and hertz overflows a 32-bit int
`define KPM_DEBOUNCE_CYC    ((`KPM_CLK_HZ / 1000) * `KPM_DEBOUNCE_MS)
`define KPM_SETUP_HOLD_CYC  ((`KPM_CLK_HZ / 1000) * `KPM_SETUP_HOLD_MS)
`define KPM_BLINK_HALF_CYC  ((`KPM_CLK_HZ / 1000) * `KPM_BLINK_HALF_MS)

// ==================================================
// Register byte addresses
`define KPM_ADDR_CTRL       32'h0000_0000
`define KPM_ADDR_STATUS     32'h0000_0004
`define KPM_ADDR_VALUE      32'h0000_0008
`define KPM_ADDR_GAIN       32'h0000_000C

// ==================================================
// Field positions
`define KPM_CTRL_PANEL_BIT  0
`define KPM_ST_STATE_LSB    0
`define KPM_ST_LEVEL_LSB    8
`define KPM_ST_CURSOR_LSB   12
`define KPM_ST_ITEM_LSB     16
`define KPM_ST_SEL_LSB      20

// ==================================================
// Key vector positions
`define KPM_KEY_UP          0
`define KPM_KEY_DOWN        1
`define KPM_KEY_ENTER       2
`define KPM_KEY_RESET       3
`define KPM_KEY_SETUP       4
`define KPM_KEY_LIMITS      5

// ==================================================
// Reset values; codes and gain as {msd[4:0], four BCD digits}, panel as one bit
`define KPM_LEVEL_ONE_RST   21'h0_0001
`define KPM_LEVEL_TWO_RST   21'h0_0002
`define KPM_LEVEL_THREE_RST 21'h0_0003
`define KPM_GAIN_RST        21'h0_0001
`define KPM_PANEL_RST       1'b1

`endif

// ==== inc/kpm_pkg.sv ====
// Types shared by the keypad number-entry and menu interpreter.
// Assumes nothing beyond a SystemVerilog compiler.
package kpm_pkg;

   // ==================================================
   // Five-digit number: signed leftmost digit and four BCD digits
   typedef struct packed {
      logic signed [4:0]     msd;
      logic [3:0][3:0]       low;
   } kpm_num_t;

   // ==================================================
   // Top-level states
   typedef enum logic [5:0] {
      KPM_RUN    = 6'b000001,
      KPM_LEVEL  = 6'b000010,
      KPM_NUM    = 6'b000100,
      KPM_MENU   = 6'b001000,
      KPM_FP_SUB = 6'b010000,
      KPM_PW_SUB = 6'b100000
   } kpm_state_t;

   // What a committed number is used for
   typedef enum logic [2:0] {
      KPM_USE_PASS = 3'b001,
      KPM_USE_CODE = 3'b010,
      KPM_USE_GAIN = 3'b100
   } kpm_use_t;

   // Main-menu items in menu order
   typedef enum logic [1:0] {
      KPM_ITEM_PANEL = 2'h0,
      KPM_ITEM_PWED  = 2'h1,
      KPM_ITEM_GAIN  = 2'h2,
      KPM_ITEM_RUN   = 2'h3
   } kpm_item_t;

endpackage

// ==== rtl/kpm_keypad_menu.sv ====
// Keypad interpreter: access levels, password check, menu stepping,
// front-panel and password-edit sub-menus, five-digit number entry.
// Assumes key inputs are synchronous to pclk and active high while held.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "kpm_cfg.svh"

module kpm_keypad_menu
   import kpm_pkg::*;
#(
   parameter int DEBOUNCE_CYC   = `KPM_DEBOUNCE_CYC,
   parameter int SETUP_HOLD_CYC = `KPM_SETUP_HOLD_CYC,
   parameter int BLINK_HALF_CYC = `KPM_BLINK_HALF_CYC
) (
   // APB slave
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output var  logic [31:0]  prdata,
   output var  logic         pready,
   output var  logic         pslverr,
   // Keypad, held level per key
   input  wire logic         key_up,
   input  wire logic         key_down,
   input  wire logic         key_enter,
   input  wire logic         key_reset,
   input  wire logic         key_setup,
   input  wire logic         key_limits,
   // Display
   output var  kpm_num_t     disp_value,
   output var  logic [4:0]   disp_blank,
   output var  kpm_state_t   disp_state,
   output var  kpm_item_t    disp_item,
   output var  logic [1:0]   disp_sel,
   output var  logic         disp_choice,
   // Run-time key functions, one pulse per press: up, down, enter, reset
   output var  logic [3:0]   run_key_pulse,
   output var  logic         panel_keys_on
);

   localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
   localparam int HLW = $clog2(SETUP_HOLD_CYC + 1);
   localparam int BLW = $clog2(BLINK_HALF_CYC + 1);

   typedef struct packed {
      kpm_state_t              state;
      kpm_use_t                use_of;
      kpm_item_t               item;
      logic [1:0]              level;
      logic [1:0]              sel;
      logic                    choice;
      logic [1:0]              shown_sel;
      logic [2:0]              pos;
      kpm_num_t                num;
      kpm_num_t                orig;
      kpm_num_t [2:0]          codes;
      kpm_num_t                gain;
      logic                    panel_on;
      logic [5:0]              raw_last;
      logic [5:0]              deb;
      logic [5:0]              deb_prev;
      logic [DBW-1:0]          db_cnt;
      logic [HLW-1:0]          hold_cnt;
      logic [BLW-1:0]          blink_cnt;
      logic                    blink_ph;
      logic [4:0]              blank;
      logic [3:0]              run_pulse;
      logic                    rdy;
      logic [31:0]             rdata;
      logic                    err;
   } kpm_st_t;

   kpm_st_t cur;
   kpm_st_t next_st;

   // ==================================================
   // Digit arithmetic
   function automatic kpm_num_t step_digit(kpm_num_t n, logic [2:0] pos, logic up);
      kpm_num_t r;
      r = n;
      if (pos == 3'd4) begin
         if (up) begin
            r.msd = (n.msd == 5'sd9) ? -5'sd9 : n.msd + 5'sd1;
         end else begin
            r.msd = (n.msd == -5'sd9) ? 5'sd9 : n.msd - 5'sd1;
         end
      end else if (up) begin
         r.low[pos[1:0]] = (n.low[pos[1:0]] == 4'h9) ? 4'h0 : n.low[pos[1:0]] + 4'h1;
      end else begin
         r.low[pos[1:0]] = (n.low[pos[1:0]] == 4'h0) ? 4'h9 : n.low[pos[1:0]] - 4'h1;
      end
      return r;
   endfunction

   function automatic logic [31:0] num_word(kpm_num_t n);
      return {11'h000, n};
   endfunction

   // ==================================================
   // Next state
   logic [5:0] raw;
   logic [5:0] press;
   logic       p_up;
   logic       p_down;
   logic       p_enter;
   logic       p_reset;
   logic       p_chord;
   logic       p_limits;
   logic       commit;
   logic       wr;

   always_comb begin
      next_st = cur;
      raw = {key_limits, key_setup, key_reset, key_enter, key_down, key_up};
      commit = 1'b0;
      wr = 1'b0;

      // Whole key vector must sit still before it is accepted
      next_st.raw_last = raw;
      next_st.deb_prev = cur.deb;
      if (raw != cur.raw_last) begin
         next_st.db_cnt = '0;
      end else if (cur.db_cnt == DBW'(DEBOUNCE_CYC - 1)) begin
         next_st.deb = raw;
      end else begin
         next_st.db_cnt = cur.db_cnt + DBW'(1);
      end
      press = cur.deb & ~cur.deb_prev;
      p_up = press[`KPM_KEY_UP];
      p_down = press[`KPM_KEY_DOWN];
      p_limits = press[`KPM_KEY_LIMITS];
      // A chord is a new enter or reset edge while the other is held
      p_chord = (press[`KPM_KEY_ENTER] | press[`KPM_KEY_RESET]) &
                cur.deb[`KPM_KEY_ENTER] & cur.deb[`KPM_KEY_RESET];
      p_enter = press[`KPM_KEY_ENTER] & ~cur.deb[`KPM_KEY_RESET];
      p_reset = press[`KPM_KEY_RESET] & ~cur.deb[`KPM_KEY_ENTER];

      next_st.run_pulse = 4'h0;
      if (cur.blink_cnt == BLW'(BLINK_HALF_CYC - 1)) begin
         next_st.blink_cnt = '0;
         next_st.blink_ph = ~cur.blink_ph;
      end else begin
         next_st.blink_cnt = cur.blink_cnt + BLW'(1);
      end

      case (cur.state)
         KPM_RUN: begin
            // Setup is honoured even with the panel off
            next_st.run_pulse = cur.panel_on ? press[3:0] : 4'h0;
            if (!cur.deb[`KPM_KEY_SETUP]) begin
               next_st.hold_cnt = '0;
            end else if (cur.hold_cnt == HLW'(SETUP_HOLD_CYC - 1)) begin
               next_st.hold_cnt = '0;
               next_st.level = 2'd0;
               next_st.state = KPM_LEVEL;
            end else begin
               next_st.hold_cnt = cur.hold_cnt + HLW'(1);
            end
         end
         KPM_LEVEL: begin
            if (p_up) begin
               next_st.level = (cur.level == 2'd2) ? 2'd0 : cur.level + 2'd1;
            end else if (p_down) begin
               next_st.level = (cur.level == 2'd0) ? 2'd2 : cur.level - 2'd1;
            end else if (p_limits) begin
               next_st.num = '0;
               next_st.orig = '0;
               next_st.pos = 3'd0;
               next_st.use_of = KPM_USE_PASS;
               next_st.state = KPM_NUM;
            end else if (p_reset) begin
               next_st.state = KPM_RUN;
            end
         end
         KPM_NUM: begin
            if (p_up || p_down) begin
               next_st.num = step_digit(cur.num, cur.pos, p_up);
            end else if (p_enter) begin
               if (cur.pos == 3'd4) begin
                  commit = 1'b1;
               end else begin
                  next_st.pos = cur.pos + 3'd1;
               end
            end else if (p_chord) begin
               commit = 1'b1;
            end else if (p_reset) begin
               next_st.num = cur.orig;
               next_st.pos = 3'd0;
            end
            if (commit) begin
               case (cur.use_of)
                  KPM_USE_PASS: begin
                     if (cur.num == cur.codes[cur.level]) begin
                        // Level three opens the whole menu, others only run
                        next_st.item = (cur.level == 2'd2) ? KPM_ITEM_PANEL : KPM_ITEM_RUN;
                        next_st.state = KPM_MENU;
                     end else begin
                        next_st.state = KPM_RUN;
                     end
                  end
                  KPM_USE_CODE: begin
                     next_st.codes[cur.sel] = cur.num;
                     next_st.sel = (cur.sel == 2'd2) ? 2'd0 : cur.sel + 2'd1;
                     next_st.state = KPM_PW_SUB;
                  end
                  default: begin
                     next_st.gain = cur.num;
                     next_st.item = KPM_ITEM_RUN;
                     next_st.state = KPM_MENU;
                  end
               endcase
            end
         end
         KPM_MENU: begin
            if (p_down && cur.item != KPM_ITEM_RUN) begin
               next_st.item = kpm_item_t'(cur.item + 2'd1);
            end else if (p_up && cur.level == 2'd2 && cur.item != KPM_ITEM_PANEL) begin
               next_st.item = kpm_item_t'(cur.item - 2'd1);
            end else if (p_reset) begin
               next_st.state = KPM_RUN;
            end else if (p_enter) begin
               case (cur.item)
                  KPM_ITEM_PANEL: begin
                     next_st.choice = cur.panel_on;
                     next_st.state = KPM_FP_SUB;
                  end
                  KPM_ITEM_PWED: begin
                     next_st.sel = 2'd0;
                     next_st.state = KPM_PW_SUB;
                  end
                  KPM_ITEM_GAIN: begin
                     next_st.num = cur.gain;
                     next_st.orig = cur.gain;
                     next_st.pos = 3'd0;
                     next_st.use_of = KPM_USE_GAIN;
                     next_st.state = KPM_NUM;
                  end
                  default: begin
                     next_st.state = KPM_RUN;
                  end
               endcase
            end
         end
         KPM_FP_SUB: begin
            if (p_up || p_down) begin
               next_st.choice = ~cur.choice;
            end else if (p_enter || p_reset) begin
               if (p_enter) begin
                  next_st.panel_on = cur.choice;
               end
               next_st.item = KPM_ITEM_PWED;
               next_st.state = KPM_MENU;
            end
         end
         KPM_PW_SUB: begin
            if (p_up) begin
               next_st.sel = (cur.sel == 2'd2) ? 2'd0 : cur.sel + 2'd1;
            end else if (p_down) begin
               next_st.sel = (cur.sel == 2'd0) ? 2'd2 : cur.sel - 2'd1;
            end else if (p_enter) begin
               next_st.num = cur.codes[cur.sel];
               next_st.orig = cur.codes[cur.sel];
               next_st.pos = 3'd0;
               next_st.use_of = KPM_USE_CODE;
               next_st.state = KPM_NUM;
            end else if (p_reset) begin
               next_st.item = KPM_ITEM_GAIN;
               next_st.state = KPM_MENU;
            end
         end
         default: begin
            next_st.state = KPM_RUN;
         end
      endcase

      // Blank the active digit in the off phase of the blink
      next_st.blank = 5'h00;
      if (next_st.state == KPM_NUM && next_st.blink_ph) begin
         next_st.blank = 5'h01 << next_st.pos;
      end
      // Level in the level prompt, else code index; registered for the pins
      next_st.shown_sel = (next_st.state == KPM_LEVEL) ? next_st.level : next_st.sel;

      // ==================================================
      // APB: one wait state, data and error latched on the same edge as pready
      if (psel && penable && !cur.rdy) begin
         next_st.rdy = 1'b1;
         next_st.err = 1'b0;
         next_st.rdata = 32'h0000_0000;
         if (paddr == `KPM_ADDR_CTRL) begin
            next_st.rdata[`KPM_CTRL_PANEL_BIT] = cur.panel_on;
         end else if (paddr == `KPM_ADDR_STATUS) begin
            next_st.rdata[`KPM_ST_STATE_LSB +: 6] = cur.state;
            next_st.rdata[`KPM_ST_LEVEL_LSB +: 2] = cur.level;
            next_st.rdata[`KPM_ST_CURSOR_LSB +: 3] = cur.pos;
            next_st.rdata[`KPM_ST_ITEM_LSB +: 2] = cur.item;
            next_st.rdata[`KPM_ST_SEL_LSB +: 2] = cur.sel;
         end else if (paddr == `KPM_ADDR_VALUE) begin
            next_st.rdata = num_word(cur.num);
         end else if (paddr == `KPM_ADDR_GAIN) begin
            next_st.rdata = num_word(cur.gain);
         end else begin
            next_st.err = 1'b1;
         end
      end else if (psel && penable && cur.rdy) begin
         next_st.rdy = 1'b0;
         next_st.err = 1'b0;
         wr = pwrite;
      end
      // Software writes land last, so they win over a keypad store
      if (wr && paddr == `KPM_ADDR_CTRL) begin
         next_st.panel_on = pwdata[`KPM_CTRL_PANEL_BIT];
      end else if (wr && paddr == `KPM_ADDR_GAIN) begin
         next_st.gain = pwdata[20:0];
      end
   end

   // ==================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
         cur.state <= KPM_RUN;
         cur.use_of <= KPM_USE_PASS;
         cur.item <= KPM_ITEM_PANEL;
         cur.codes[0] <= `KPM_LEVEL_ONE_RST;
         cur.codes[1] <= `KPM_LEVEL_TWO_RST;
         cur.codes[2] <= `KPM_LEVEL_THREE_RST;
         cur.gain <= `KPM_GAIN_RST;
         cur.panel_on <= `KPM_PANEL_RST;
      end else begin
         cur <= next_st;
      end
   end

   // ==================================================
   // Outputs, all straight from the state register
   assign prdata = cur.rdata;
   assign pready = cur.rdy;
   assign pslverr = cur.err;
   assign disp_value = cur.num;
   assign disp_blank = cur.blank;
   assign disp_state = cur.state;
   assign disp_item = cur.item;
   assign disp_sel = cur.shown_sel;
   assign disp_choice = cur.choice;
   assign run_key_pulse = cur.run_pulse;
   assign panel_keys_on = cur.panel_on;

endmodule // kpm_keypad_menu

`default_nettype wire

// ==== tb/kpm_keypad_menu_monitor.sv ====
// Checker for the keypad menu interpreter, bound to its top module.
// Assumes one clock, pclk, and the asynchronous active-low presetn.
`timescale 1ns/1ns
`default_nettype none

module kpm_monitor
   import kpm_pkg::*;
#(
   parameter int SETUP_HOLD_CYC = 20
) (
   // Clock and reset
   input wire logic         pclk,
   input wire logic         presetn,
   // APB
   input wire logic         psel,
   input wire logic         penable,
   input wire logic [31:0]  paddr,
   input wire logic         pready,
   input wire logic         pslverr,
   // Keys and display
   input wire logic         key_setup,
   input wire kpm_num_t     disp_value,
   input wire logic [4:0]   disp_blank,
   input wire kpm_state_t   disp_state,
   input wire kpm_item_t    disp_item,
   input wire logic [3:0]   run_key_pulse,
   input wire logic         panel_keys_on
);
   // ====================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic in_num;
   assign in_num = (disp_state == KPM_NUM);

   entry_cursor_a: assert property ($rose(in_num) |-> disp_blank[4:1] == 4'h0)
      else $error("cursor not on rightmost digit at entry");
   pass_zero_a: assert property ($rose(in_num) && $past(disp_state) == KPM_LEVEL
      |-> disp_value == 21'h0_0000) else $error("password prompt not zero");
   digit_range_a: assert property (in_num |-> disp_value.low[0] <= 4'h9
      && disp_value.low[1] <= 4'h9 && disp_value.low[2] <= 4'h9 && disp_value.low[3] <= 4'h9)
      else $error("digit outside 0 to 9");
   sign_range_a: assert property (in_num |-> $signed(disp_value.msd) >= -9
      && $signed(disp_value.msd) <= 9) else $error("leading digit outside -9 to 9");
   one_blank_a: assert property (disp_blank != 5'h00 |-> in_num && $onehot(disp_blank))
      else $error("blanking outside entry or on two digits");
   setup_hold_a: assert property ($rose(disp_state == KPM_LEVEL)
      |-> $past(key_setup, SETUP_HOLD_CYC) && $past(disp_state) == KPM_RUN)
      else $error("level prompt without a long setup hold");
   run_pulse_a: assert property (run_key_pulse != 4'h0
      |-> $past(panel_keys_on) && $past(disp_state) == KPM_RUN) else $error("run key leaked");
   one_pulse_a: assert property (run_key_pulse != 4'h0 |=> run_key_pulse == 4'h0)
      else $error("run key pulse longer than one cycle");
   panel_exit_a: assert property ($past(disp_state) == KPM_FP_SUB && disp_state == KPM_MENU
      |-> disp_item == KPM_ITEM_PWED) else $error("wrong item after panel sub-menu");
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle into access");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready stood two cycles");
   bad_addr_a: assert property (pready && paddr > 32'h0000_000C |-> pslverr)
      else $error("unmapped address without error");

   cover property ($rose(in_num));
   cover property (disp_state == KPM_FP_SUB);
   cover property (disp_state == KPM_PW_SUB);
endmodule // kpm_monitor

bind kpm_keypad_menu kpm_monitor #(.SETUP_HOLD_CYC(SETUP_HOLD_CYC)) i_kpm_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .key_setup(key_setup), .disp_value(disp_value),
   .disp_blank(disp_blank), .disp_state(disp_state), .disp_item(disp_item),
   .run_key_pulse(run_key_pulse), .panel_keys_on(panel_keys_on)
);

`default_nettype wire

// ==== tb/kpm_operator.sv ====
// Operator model: presses keypad keys one at a time or as a chord.
// Assumes press is called from the bench; keys are active high.
`timescale 1ns/1ns
`default_nettype none

module kpm_operator #(
   parameter int HOLD_LONG = 40
) (
   // Clock
   input  wire logic pclk,
   // Keys, high while held
   output var  logic key_up,
   output var  logic key_down,
   output var  logic key_enter,
   output var  logic key_reset,
   output var  logic key_setup,
   output var  logic key_limits
);
   // ====================
   // Key presses
   initial {key_limits, key_setup, key_reset, key_enter, key_down, key_up} = 6'h00;

   // Released keys read low, as buttons with pull-downs; one press per release
   task automatic press(input logic [5:0] mask, input int n, input logic long);
      repeat (n) begin
         @(posedge pclk);
         {key_limits, key_setup, key_reset, key_enter, key_down, key_up} <= mask;
         repeat (long ? HOLD_LONG : 8) @(posedge pclk);
         {key_limits, key_setup, key_reset, key_enter, key_down, key_up} <= 6'h00;
         repeat (8) @(posedge pclk);
      end
   endtask
endmodule // kpm_operator

`default_nettype wire

// ==== tb/testbench.sv ====
// Testbench: APB register access and operator key sequences.
// Assumes shortened counts: debounce 4, setup hold 20, blink 8.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) check((a) === (b), 64'(a), 64'(b))

module testbench;
   import kpm_pkg::*;

   localparam logic [5:0] U = 6'h01, D = 6'h02, E = 6'h04, R = 6'h08, S = 6'h10, L = 6'h20;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        er, key_up, key_down, key_enter, key_reset, key_setup, key_limits;
   kpm_num_t    disp_value;
   logic [4:0]  disp_blank;
   kpm_state_t  disp_state;
   kpm_item_t   disp_item;
   logic [1:0]  disp_sel;
   logic        disp_choice, panel_keys_on;
   logic [3:0]  run_key_pulse;
   logic [4:0]  seen_blank;
   int          errors, compares, pulses;

   kpm_keypad_menu #(.DEBOUNCE_CYC(4), .SETUP_HOLD_CYC(20), .BLINK_HALF_CYC(8)) i_kpm_keypad_menu (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_up(key_up), .key_down(key_down), .key_enter(key_enter), .key_reset(key_reset),
      .key_setup(key_setup), .key_limits(key_limits), .disp_value(disp_value),
      .disp_blank(disp_blank), .disp_state(disp_state), .disp_item(disp_item),
      .disp_sel(disp_sel), .disp_choice(disp_choice), .run_key_pulse(run_key_pulse),
      .panel_keys_on(panel_keys_on));

   kpm_operator i_kpm_operator (
      .pclk(pclk), .key_up(key_up), .key_down(key_down), .key_enter(key_enter),
      .key_reset(key_reset), .key_setup(key_setup), .key_limits(key_limits));

   // ====================
   // Clock, pulse counter, watchdog
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (run_key_pulse !== 4'h0 && presetn === 1'b1) pulses <= pulses + 1;
      seen_blank <= seen_blank | disp_blank;
   end

   initial begin
      #(50 * 8000);
      errors++;
      summarize;
   end

   // ====================
   // Tasks
   task automatic check(input bit ok, input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (!ok) begin
         errors++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is sampled high; the watchdog ends a hang
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic summarize;
      if (errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ====================
   // Main sequence
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pulses = 0;
      seen_blank = 5'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 32'h0000_0000, 32'h0);
      `CHK(rd, 32'h0000_0001);
      apb(1'b0, 32'h0000_0010, 32'h0);
      `CHK({er, rd}, 33'h1_0000_0000);
      apb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
      `CHK(er, 1'b1);
      apb(1'b0, 32'h0000_000C, 32'h0);
      `CHK(rd, 32'h0000_0001);
      i_kpm_operator.press(U, 1, 1'b0);
      `CHK(pulses, 1);
      // Level three with its default code, entered by chord
      i_kpm_operator.press(S, 1, 1'b1);
      `CHK(disp_state, KPM_LEVEL);
      i_kpm_operator.press(U, 2, 1'b0);
      `CHK(disp_sel, 2'h2);
      i_kpm_operator.press(L, 1, 1'b0);
      `CHK({disp_state, disp_value}, {KPM_NUM, 21'h0_0000});
      i_kpm_operator.press(U, 3, 1'b0);
      `CHK(disp_value, 21'h0_0003);
      i_kpm_operator.press(D, 4, 1'b0);
      `CHK(disp_value, 21'h0_0009);
      i_kpm_operator.press(U, 4, 1'b0);
      `CHK(seen_blank, 5'h01);
      i_kpm_operator.press(E | R, 1, 1'b0);
      `CHK({disp_state, disp_item}, {KPM_MENU, KPM_ITEM_PANEL});
      // Menu stepping and the panel sub-menu
      i_kpm_operator.press(D, 2, 1'b0);
      `CHK(disp_item, KPM_ITEM_GAIN);
      i_kpm_operator.press(U, 2, 1'b0);
      `CHK(disp_item, KPM_ITEM_PANEL);
      i_kpm_operator.press(E, 1, 1'b0);
      `CHK(disp_state, KPM_FP_SUB);
      i_kpm_operator.press(D, 1, 1'b0);
      `CHK(disp_choice, 1'b0);
      i_kpm_operator.press(R, 1, 1'b0);
      `CHK({panel_keys_on, disp_item}, {1'b1, KPM_ITEM_PWED});
      i_kpm_operator.press(U, 1, 1'b0);
      i_kpm_operator.press(E, 1, 1'b0);
      i_kpm_operator.press(D, 1, 1'b0);
      i_kpm_operator.press(E, 1, 1'b0);
      `CHK({panel_keys_on, disp_item}, {1'b0, KPM_ITEM_PWED});
      // Level two code becomes 00010, built right to left
      i_kpm_operator.press(E, 1, 1'b0);
      i_kpm_operator.press(U, 1, 1'b0);
      `CHK({disp_state, disp_sel}, {KPM_PW_SUB, 2'h1});
      apb(1'b0, 32'h0000_0004, 32'h0);
      `CHK(rd, 32'h0011_0220);
      i_kpm_operator.press(E, 1, 1'b0);
      `CHK(disp_value, 21'h0_0002);
      i_kpm_operator.press(D, 2, 1'b0);
      i_kpm_operator.press(E, 1, 1'b0);
      i_kpm_operator.press(U, 1, 1'b0);
      `CHK(disp_value, 21'h0_0010);
      i_kpm_operator.press(E | R, 1, 1'b0);
      `CHK({disp_state, disp_sel}, {KPM_PW_SUB, 2'h2});
      i_kpm_operator.press(R, 1, 1'b0);
      `CHK({disp_state, disp_item}, {KPM_MENU, KPM_ITEM_GAIN});
      // Gain entry: sign digit, restart, commit on the leftmost digit
      i_kpm_operator.press(E, 1, 1'b0);
      `CHK(disp_value, 21'h0_0001);
      i_kpm_operator.press(E, 4, 1'b0);
      i_kpm_operator.press(D, 1, 1'b0);
      `CHK(disp_value, 21'h1F_0001);
      apb(1'b0, 32'h0000_0008, 32'h0);
      `CHK(rd, 32'h001F_0001);
      i_kpm_operator.press(R, 1, 1'b0);
      `CHK(disp_value, 21'h0_0001);
      i_kpm_operator.press(U, 1, 1'b0);
      `CHK(disp_value, 21'h0_0002);
      i_kpm_operator.press(E, 4, 1'b0);
      i_kpm_operator.press(D, 1, 1'b0);
      i_kpm_operator.press(E, 1, 1'b0);
      `CHK({disp_state, disp_item}, {KPM_MENU, KPM_ITEM_RUN});
      apb(1'b0, 32'h0000_000C, 32'h0);
      `CHK(rd, 32'h001F_0002);
      i_kpm_operator.press(R, 1, 1'b0);
      // Panel off: run keys held back, setup still honoured
      i_kpm_operator.press(U, 1, 1'b0);
      `CHK(pulses, 1);
      i_kpm_operator.press(S, 1, 1'b1);
      i_kpm_operator.press(U, 1, 1'b0);
      i_kpm_operator.press(L, 1, 1'b0);
      i_kpm_operator.press(E, 1, 1'b0);
      i_kpm_operator.press(U, 1, 1'b0);
      i_kpm_operator.press(E | R, 1, 1'b0);
      `CHK({disp_state, disp_item}, {KPM_MENU, KPM_ITEM_RUN});
      i_kpm_operator.press(R, 1, 1'b0);
      apb(1'b1, 32'h0000_0000, 32'h0000_0001);
      i_kpm_operator.press(U, 1, 1'b0);
      `CHK(pulses, 2);
      // Wrong code for level one
      i_kpm_operator.press(S, 1, 1'b1);
      i_kpm_operator.press(L, 1, 1'b0);
      i_kpm_operator.press(E | R, 1, 1'b0);
      `CHK(disp_state, KPM_RUN);
      summarize;
   end
endmodule // testbench

`default_nettype wire
